// ---- logic/bus_cycle_sequencer.sv ----
`timescale 1ns/10ps
module bus_cycle_sequencer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Instruction issue
  input wire logic start_in,
  input wire logic [1:0] op_class_in,
  input wire logic link_in,
  input wire logic shift_by_reg_in,
  input wire logic dest_pc_in,
  input wire logic compare_in,
  input wire logic psr_transfer_in,
  input wire logic set_flags_in,
  input wire logic multiply_accumulate_op_in,
  input wire logic byte_in,
  input wire logic base_writeback_in,
  input wire logic [3:0] dest_idx_in,
  input wire logic [3:0] base_idx_in,
  output logic ready_out,
  // Datapath operands
  input wire logic [31:0] alu_result_in,
  input wire logic [31:0] shift_reg_in,
  input wire logic [31:0] multiplicand_in,
  input wire logic [31:0] multiplier_in,
  input wire logic [31:0] accumulate_in,
  input wire logic [31:0] read_data_in,
  input wire logic abort_in,
  // Memory bus
  output logic [31:0] address_out,
  output logic byte_word_select_n_out,
  output logic read_write_select_n_out,
  output logic opcode_fetch_n_out,
  output logic memory_request_n_out,
  output logic sequential_cycle_out,
  // Register file and core control
  output logic reg_write_en_out,
  output logic [3:0] reg_write_idx_out,
  output logic [31:0] reg_write_data_out,
  output logic flags_write_out,
  output logic [7:0] shift_latch_out,
  output logic pipeline_flush_out,
  output logic exception_block_out
);

  typedef struct packed {
    seq_pkg::state_t state;
    logic link;
    logic dest_pc;
    logic compare;
    logic set_flags;
    logic byte_sel;
    logic writeback;
    logic mul_last;
    logic aborted;
    logic load_pc;
    logic [3:0] dest_idx;
    logic [3:0] base_idx;
    logic [31:0] ret_addr;
    logic [31:0] load_data;
    logic [31:0] addr;
    logic bw_n;
    logic opc_n;
    logic mreq_n;
    logic seq;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_data;
    logic flags_wr;
    logic [7:0] shift_latch;
    logic flush;
    logic exc_block;
  } seq_state_t;

  seq_state_t cur;
  seq_state_t nxt;
  seq_pkg::state_t ns;
  seq_pkg::state_t first;
  logic go;
  logic ready;
  logic fp_load;
  logic fp_adv;
  logic [31:0] fp_value;
  logic [31:0] fetch_ptr;
  logic mul_load;
  logic mul_step;
  logic last_now;
  logic last_next;
  logic [31:0] mul_result;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  fetch_pointer u_fetch (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .load_in(fp_load),
    .load_value_in(fp_value),
    .advance_in(fp_adv),
    .pointer_out(fetch_ptr)
  );

  booth_multiplier u_booth (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .load_in(mul_load),
    .step_in(mul_step),
    .multiplicand_in(multiplicand_in),
    .multiplier_in(multiplier_in),
    .init_in(multiply_accumulate_op_in ? accumulate_in :
      32'h0000_0000),
    .last_now_out(last_now),
    .last_next_out(last_next),
    .step_result_out(mul_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance of a new instruction

  always_comb begin
    unique case (cur.state)
      seq_pkg::ST_IDLE, seq_pkg::ST_RF2, seq_pkg::ST_LD5: ready = 1'b1;
      seq_pkg::ST_DP1, seq_pkg::ST_DPS2: ready = !cur.dest_pc;
      seq_pkg::ST_MUN: ready = cur.mul_last;
      seq_pkg::ST_LD3: ready = !cur.load_pc;
      default: ready = 1'b0;
    endcase
  end

  assign go = start_in && ready;
  assign mul_load = go && (op_class_in == seq_pkg::OP_MUL);

  always_comb begin
    unique case (seq_pkg::op_class_t'(op_class_in))
      seq_pkg::OP_BRANCH: first = seq_pkg::ST_BR1;
      seq_pkg::OP_DATA:
        first = shift_by_reg_in ? seq_pkg::ST_DPS1 : seq_pkg::ST_DP1;
      seq_pkg::OP_MUL: first = seq_pkg::ST_MU1;
      seq_pkg::OP_LOAD: first = seq_pkg::ST_LD1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State sequencing and register writes

  always_comb begin
    nxt = cur;
    ns = cur.state;
    nxt.wr_en = 1'b0;
    nxt.wr_idx = cur.dest_idx;
    nxt.wr_data = alu_result_in;
    nxt.flags_wr = 1'b0;
    nxt.flush = 1'b0;
    mul_step = 1'b0;
    unique case (cur.state)
      seq_pkg::ST_IDLE: ns = seq_pkg::ST_IDLE;
      seq_pkg::ST_BR1: begin
        ns = seq_pkg::ST_RF1;
        nxt.flush = 1'b1;
        nxt.ret_addr = cur.addr;
        nxt.wr_en = cur.link;
        nxt.wr_idx = seq_pkg::LINK_REG_IDX;
        nxt.wr_data = cur.addr;
      end
      seq_pkg::ST_RF1: begin
        ns = seq_pkg::ST_RF2;
        nxt.wr_en = cur.link;
        nxt.wr_idx = seq_pkg::LINK_REG_IDX;
        nxt.wr_data = cur.ret_addr - seq_pkg::WORD_STEP;
      end
      seq_pkg::ST_DP1, seq_pkg::ST_DPS2: begin
        nxt.flags_wr = cur.compare || cur.set_flags;
        nxt.wr_en = !cur.compare && !cur.dest_pc;
        if (cur.dest_pc) begin
          ns = seq_pkg::ST_RF1;
          nxt.flush = 1'b1;
        end
      end
      seq_pkg::ST_DPS1: begin
        ns = seq_pkg::ST_DPS2;
        nxt.shift_latch = shift_reg_in[seq_pkg::SHIFT_LATCH_BITS-1:0];
      end
      seq_pkg::ST_MU1: begin
        ns = seq_pkg::ST_MUN;
        nxt.mul_last = last_now;
      end
      seq_pkg::ST_MUN: begin
        mul_step = 1'b1;
        nxt.mul_last = last_next;
        if (cur.mul_last) begin
          nxt.wr_en = 1'b1;
          nxt.wr_data = mul_result;
        end
      end
      seq_pkg::ST_LD1: ns = seq_pkg::ST_LD2;
      seq_pkg::ST_LD2: begin
        ns = seq_pkg::ST_LD3;
        nxt.load_data = read_data_in;
        nxt.aborted = abort_in;
        nxt.load_pc = cur.dest_pc && !abort_in;
        nxt.wr_en = cur.writeback;
        nxt.wr_idx = cur.base_idx;
      end
      seq_pkg::ST_LD3: begin
        nxt.wr_en = !cur.aborted && !cur.load_pc;
        nxt.wr_data = cur.load_data;
        if (cur.load_pc) begin
          ns = seq_pkg::ST_LD4;
          nxt.flush = 1'b1;
        end
      end
      seq_pkg::ST_LD4: ns = seq_pkg::ST_LD5;
      seq_pkg::ST_LD5: ns = seq_pkg::ST_IDLE;
      default: ns = seq_pkg::ST_IDLE;
    endcase
    if (ready) begin
      ns = go ? first : seq_pkg::ST_IDLE;
    end
    if (go) begin
      nxt.link = link_in && (op_class_in == seq_pkg::OP_BRANCH);
      nxt.compare = compare_in;
      nxt.set_flags = set_flags_in;
      nxt.dest_pc = dest_pc_in && !psr_transfer_in && !compare_in;
      nxt.byte_sel = byte_in;
      nxt.writeback = base_writeback_in;
      nxt.dest_idx = dest_idx_in;
      nxt.base_idx = base_idx_in;
      nxt.mul_last = 1'b0;
      nxt.aborted = 1'b0;
      nxt.load_pc = 1'b0;
    end
    nxt.state = ns;
    // Bus cycle of the next state; request and sequential describe the one
    // after it, so they leave one cycle ahead of their bus cycle
    fp_load = 1'b0;
    fp_adv = 1'b0;
    fp_value = alu_result_in + seq_pkg::WORD_STEP;
    nxt.addr = fetch_ptr;
    nxt.bw_n = 1'b1;
    nxt.opc_n = 1'b1;
    nxt.mreq_n = 1'b1;
    nxt.seq = 1'b0;
    nxt.exc_block = 1'b0;
    unique case (ns)
      seq_pkg::ST_IDLE: nxt.mreq_n = 1'b1;
      seq_pkg::ST_BR1, seq_pkg::ST_LD1: begin
        fp_adv = 1'b1;
        nxt.opc_n = 1'b0;
        nxt.mreq_n = 1'b0;
      end
      seq_pkg::ST_DP1: begin
        fp_adv = 1'b1;
        nxt.opc_n = 1'b0;
        nxt.mreq_n = 1'b0;
        nxt.seq = !nxt.dest_pc;
      end
      seq_pkg::ST_DPS1, seq_pkg::ST_MU1: begin
        fp_adv = 1'b1;
        nxt.opc_n = 1'b0;
        nxt.mreq_n = 1'b1;
      end
      seq_pkg::ST_DPS2: begin
        nxt.mreq_n = 1'b0;
        nxt.seq = !cur.dest_pc;
      end
      seq_pkg::ST_MUN: begin
        nxt.mreq_n = !nxt.mul_last;
        nxt.seq = nxt.mul_last;
      end
      seq_pkg::ST_RF1: begin
        fp_load = 1'b1;
        nxt.addr = alu_result_in;
        nxt.opc_n = 1'b0;
        nxt.mreq_n = 1'b0;
        nxt.seq = 1'b1;
        nxt.exc_block = 1'b1;
      end
      seq_pkg::ST_RF2, seq_pkg::ST_LD5: begin
        fp_adv = 1'b1;
        nxt.opc_n = 1'b0;
        nxt.mreq_n = 1'b0;
        nxt.seq = 1'b1;
        nxt.exc_block = 1'b1;
      end
      seq_pkg::ST_LD2: begin
        nxt.addr = alu_result_in;
        nxt.bw_n = !cur.byte_sel;
        nxt.mreq_n = 1'b1;
      end
      seq_pkg::ST_LD3: begin
        nxt.mreq_n = 1'b0;
        nxt.seq = !nxt.load_pc;
      end
      seq_pkg::ST_LD4: begin
        fp_load = 1'b1;
        fp_value = cur.load_data + seq_pkg::WORD_STEP;
        nxt.addr = cur.load_data;
        nxt.opc_n = 1'b0;
        nxt.mreq_n = 1'b0;
        nxt.seq = 1'b1;
        nxt.exc_block = 1'b1;
      end
      default: nxt.mreq_n = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; bus outputs settle at the edge before their cycle

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cur <= '0;
      cur.state <= seq_pkg::ST_IDLE;
      cur.addr <= seq_pkg::RESET_FETCH_ADDR;
      cur.bw_n <= 1'b1;
      cur.opc_n <= 1'b1;
      cur.mreq_n <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ready_out = ready;
  assign address_out = cur.addr;
  assign byte_word_select_n_out = cur.bw_n;
  assign read_write_select_n_out = 1'b0;
  assign opcode_fetch_n_out = cur.opc_n;
  assign memory_request_n_out = cur.mreq_n;
  assign sequential_cycle_out = cur.seq;
  assign reg_write_en_out = cur.wr_en;
  assign reg_write_idx_out = cur.wr_idx;
  assign reg_write_data_out = cur.wr_data;
  assign flags_write_out = cur.flags_wr;
  assign shift_latch_out = cur.shift_latch;
  assign pipeline_flush_out = cur.flush;
  assign exception_block_out = cur.exc_block;

endmodule

// ---- shared/seq_pkg.sv ----
package seq_pkg;

  // Cycle states of the sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_BR1  = 4'h1,
    ST_RF1  = 4'h2,
    ST_RF2  = 4'h3,
    ST_DP1  = 4'h4,
    ST_DPS1 = 4'h5,
    ST_DPS2 = 4'h6,
    ST_MU1  = 4'h7,
    ST_MUN  = 4'h8,
    ST_LD1  = 4'h9,
    ST_LD2  = 4'hA,
    ST_LD3  = 4'hB,
    ST_LD4  = 4'hC,
    ST_LD5  = 4'hD
  } state_t;

  // Instruction groups
  typedef enum logic [1:0] {
    OP_BRANCH = 2'h0,
    OP_DATA   = 2'h1,
    OP_MUL    = 2'h2,
    OP_LOAD   = 2'h3
  } op_class_t;

  localparam logic [3:0] LINK_REG_IDX = 4'hE;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;
  localparam int SHIFT_LATCH_BITS = 8;
  localparam int BOOTH_SHIFT = 2;

endpackage

// ---- logic/fetch_pointer.sv ----
`timescale 1ns/10ps
module fetch_pointer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Control
  input wire logic load_in,
  input wire logic [31:0] load_value_in,
  input wire logic advance_in,
  // Pointer
  output logic [31:0] pointer_out
);

  typedef struct packed {
    logic [31:0] ptr;
  } fp_state_t;

  fp_state_t cur;
  fp_state_t nxt;

  always_comb begin
    nxt = cur;
    if (load_in) begin
      nxt.ptr = load_value_in;
    end else if (advance_in) begin
      nxt.ptr = cur.ptr + seq_pkg::WORD_STEP;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cur <= '{ptr: seq_pkg::RESET_FETCH_ADDR};
    end else begin
      cur <= nxt;
    end
  end

  assign pointer_out = cur.ptr;

endmodule

// ---- logic/booth_multiplier.sv ----
`timescale 1ns/10ps
module booth_multiplier (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Control
  input wire logic load_in,
  input wire logic step_in,
  // Operands
  input wire logic [31:0] multiplicand_in,
  input wire logic [31:0] multiplier_in,
  input wire logic [31:0] init_in,
  // Status and result
  output logic last_now_out,
  output logic last_next_out,
  output logic [31:0] step_result_out
);

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] mcand;
    logic [31:0] mplier;
    logic borrow;
  } booth_state_t;

  booth_state_t cur;
  booth_state_t nxt;
  logic [31:0] sum;

  // Radix-4 digit from two multiplier bits and the pending borrow
  always_comb begin
    unique case ({cur.mplier[1:0], cur.borrow})
      3'h1, 3'h2: sum = cur.acc + cur.mcand;
      3'h3: sum = cur.acc + {cur.mcand[30:0], 1'b0};
      3'h4: sum = cur.acc - {cur.mcand[30:0], 1'b0};
      3'h5, 3'h6: sum = cur.acc - cur.mcand;
      default: sum = cur.acc;
    endcase
  end

  always_comb begin
    nxt = cur;
    if (load_in) begin
      nxt.acc = init_in;
      nxt.mcand = multiplicand_in;
      nxt.mplier = multiplier_in;
      nxt.borrow = 1'b0;
    end else if (step_in) begin
      nxt.acc = sum;
      nxt.mcand = cur.mcand << seq_pkg::BOOTH_SHIFT;
      nxt.mplier = cur.mplier >> seq_pkg::BOOTH_SHIFT;
      nxt.borrow = cur.mplier[1];
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // This step ends the multiply, or the one after it will
  assign last_now_out = (cur.mplier[31:2] == 30'h0) && !cur.mplier[1];
  assign last_next_out = (cur.mplier[31:4] == 28'h0) && !cur.mplier[3];
  assign step_result_out = sum;

endmodule

// ---- dv/seq_props.sv ----
`timescale 1ns/10ps
module seq_props (
  // Clock and reset
  input logic clock_in,
  input logic arst_n_in,
  // Issue side
  input logic start_in,
  input logic ready_out,
  input logic [1:0] op_class_in,
  input logic shift_by_reg_in,
  input logic dest_pc_in,
  input logic compare_in,
  input logic psr_transfer_in,
  input logic byte_in,
  input logic [31:0] alu_result_in,
  input logic [31:0] shift_reg_in,
  input logic abort_in,
  // Bus and core control
  input logic [31:0] address_out,
  input logic byte_word_select_n_out,
  input logic read_write_select_n_out,
  input logic opcode_fetch_n_out,
  input logic memory_request_n_out,
  input logic sequential_cycle_out,
  input logic reg_write_en_out,
  input logic [7:0] shift_latch_out,
  input logic pipeline_flush_out,
  input logic exception_block_out
);
  logic take;
  assign take = start_in && ready_out;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////////////////////////////////////
  a_reads_only: assert property (
    !read_write_select_n_out) else $error("write select raised");
  a_branch_refill: assert property (
    take && op_class_in == 2'h0 |=> !opcode_fetch_n_out &&
    !memory_request_n_out && !sequential_cycle_out ##1
    address_out == $past(alu_result_in) && sequential_cycle_out &&
    pipeline_flush_out && exception_block_out ##1
    address_out == $past(address_out) + 32'h4 && sequential_cycle_out)
    else $error("branch cycles wrong");
  a_data_single: assert property (
    take && op_class_in == 2'h1 && !shift_by_reg_in &&
    (!dest_pc_in || compare_in || psr_transfer_in) |=>
    sequential_cycle_out && !memory_request_n_out && !opcode_fetch_n_out)
    else $error("data op cycle wrong");
  a_shift_internal: assert property (
    take && op_class_in == 2'h1 && shift_by_reg_in |=>
    memory_request_n_out && !opcode_fetch_n_out ##1
    opcode_fetch_n_out && !memory_request_n_out &&
    shift_latch_out == $past(shift_reg_in[7:0]))
    else $error("shift cycles wrong");
  a_shift_addr_hold: assert property (
    take && op_class_in == 2'h1 && shift_by_reg_in && !dest_pc_in |=>
    ##1 address_out == $past(address_out) + 32'h4 ##1 $stable(address_out))
    else $error("internal address moved");
  a_mul_internal: assert property (
    take && op_class_in == 2'h2 |=> memory_request_n_out &&
    !opcode_fetch_n_out ##1 opcode_fetch_n_out ##[0:17]
    !memory_request_n_out) else $error("multiply cycles wrong");
  a_load_cycles: assert property (
    take && op_class_in == 2'h3 |=> !memory_request_n_out &&
    !sequential_cycle_out ##1 opcode_fetch_n_out && memory_request_n_out &&
    address_out == $past(alu_result_in) &&
    byte_word_select_n_out == !$past(byte_in, 2) ##1
    !memory_request_n_out && opcode_fetch_n_out)
    else $error("load cycles wrong");
  a_compare_nowrite: assert property (
    take && op_class_in == 2'h1 && compare_in && !shift_by_reg_in |=>
    ##1 !reg_write_en_out) else $error("compare wrote register");
  a_abort_nowrite: assert property (
    take && op_class_in == 2'h3 && !dest_pc_in ##2 abort_in |=>
    ##1 !reg_write_en_out) else $error("aborted load wrote");
  a_psr_no_flush: assert property (
    take && op_class_in == 2'h1 && psr_transfer_in && !shift_by_reg_in
    |=> ##1 !pipeline_flush_out) else $error("status transfer flushed");
  c_branch: cover property (take && op_class_in == 2'h0);
  c_shift: cover property (take && op_class_in == 2'h1 && shift_by_reg_in);
  c_abort: cover property (take && op_class_in == 2'h3 ##2 abort_in);
endmodule
bind bus_cycle_sequencer seq_props i_seq_props (.*);

// ---- dv/memory_model.sv ----
`timescale 1ns/10ps
module memory_model (
  // Clock
  input logic clock_in,
  // Bus from the sequencer
  input logic [31:0] address_in,
  input logic memory_request_n_in,
  input logic abort_en_in,
  // Answer
  output logic [31:0] read_data_out,
  output logic abort_out
);
  localparam logic [31:0] DATA_KEY = 32'h5A5A_0000;
  logic req_now;
  // Request flag announces the following cycle
  always_ff @(posedge clock_in) req_now <= !memory_request_n_in;
  // Outside a requested cycle the data lines show garbage
  assign read_data_out = req_now ? (address_in ^ DATA_KEY) :
    ~(address_in ^ DATA_KEY);
  assign abort_out = abort_en_in && req_now;
endmodule

// ---- dv/bus_cycle_sequencer_tb.sv ----
`timescale 1ns/10ps
module bus_cycle_sequencer_tb;
  logic clock_in, arst_n_in, start_in, link_in, shift_by_reg_in, dest_pc_in;
  logic compare_in, psr_transfer_in, set_flags_in, multiply_accumulate_op_in;
  logic byte_in, base_writeback_in, ready_out, abort_in, abort_en;
  logic [1:0] op_class_in;
  logic [3:0] dest_idx_in, base_idx_in, reg_write_idx_out;
  logic [31:0] alu_result_in, opa, accumulate_in, read_data_in, address_out;
  logic [31:0] reg_write_data_out, fp;
  logic byte_word_select_n_out, read_write_select_n_out, opcode_fetch_n_out;
  logic memory_request_n_out, sequential_cycle_out, reg_write_en_out;
  logic flags_write_out, pipeline_flush_out, exception_block_out;
  logic [7:0] shift_latch_out;
  int failures, samples_checked;
  bus_cycle_sequencer i_bus_cycle_sequencer (.shift_reg_in(opa),
    .multiplicand_in(opa), .multiplier_in(opa), .*);
  memory_model i_memory_model (.clock_in(clock_in), .address_in(address_out),
    .memory_request_n_in(memory_request_n_out), .abort_en_in(abort_en),
    .read_data_out(read_data_in), .abort_out(abort_in));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic [2:0] f);
    check("address", address_out, a);
    check("rw_n", {31'h0, read_write_select_n_out}, 32'h0);
    check("opc_req_seq", {29'h0, opcode_fetch_n_out, memory_request_n_out,
      sequential_cycle_out}, {29'h0, f});
  endtask
  task automatic wr(input logic e, input logic [3:0] i, input logic [31:0] d);
    check("wr_en", {31'h0, reg_write_en_out}, {31'h0, e});
    if (e) begin
      check("wr_idx", {28'h0, reg_write_idx_out}, {28'h0, i});
      check("wr_data", reg_write_data_out, d);
    end
  endtask
  task automatic step;
    @(posedge clock_in);
    #1;
  endtask
  // Flags: abort, mla, link, shift, dest pc, compare, psr, byte, writeback
  task automatic go(input logic [1:0] op, input logic [8:0] f,
    input logic [31:0] alu, a);
    @(posedge clock_in);
    start_in <= 1'b1;
    op_class_in <= op;
    {abort_en, multiply_accumulate_op_in, link_in, shift_by_reg_in,
      dest_pc_in, compare_in, psr_transfer_in, byte_in,
      base_writeback_in} <= f;
    alu_result_in <= alu;
    opa <= a;
    @(posedge clock_in);
    start_in <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_data(input logic [8:0] f, input logic e);
    go(2'h1, f, 32'h0000_0055, 32'h0);
    bus(fp, 3'b001);
    step;
    wr(e, 4'h3, 32'h0000_0055);
    check("flags", {31'h0, flags_write_out}, 32'h1);
    check("flush", {31'h0, pipeline_flush_out}, 32'h0);
    fp = fp + 32'h4;
  endtask
  task automatic s_refill(input logic [1:0] op, input logic [8:0] f,
    input logic [31:0] t);
    go(op, f, t, 32'h0);
    bus(fp, 3'b000);
    step;
    bus(t, 3'b001);
    check("flush_blk", {30'h0, pipeline_flush_out, exception_block_out},
      32'h3);
    if (f[6]) wr(1'b1, seq_pkg::LINK_REG_IDX, fp);
    step;
    bus(t + 32'h4, 3'b001);
    if (f[6]) wr(1'b1, seq_pkg::LINK_REG_IDX, fp - 32'h4);
    fp = t + 32'h8;
  endtask
  task automatic s_shift;
    go(2'h1, 9'h020, 32'h0000_0077, 32'h0000_01A7);
    bus(fp, 3'b010);
    step;
    bus(fp + 32'h4, 3'b101);
    check("latch", {24'h0, shift_latch_out}, 32'h0000_00A7);
    step;
    wr(1'b1, 4'h3, 32'h0000_0077);
    fp = fp + 32'h4;
  endtask
  task automatic s_mul(input logic [8:0] f, input logic [31:0] a, p);
    int n;
    go(2'h2, f, 32'h0, a);
    bus(fp, 3'b010);
    step;
    n = 0;
    while (memory_request_n_out === 1'b1 && n < 40) begin
      bus(fp + 32'h4, 3'b110);
      step;
      n++;
    end
    bus(fp + 32'h4, 3'b101);
    if (a < 32'h2) check("mul_len", n, 32'h0);
    step;
    wr(1'b1, 4'h3, p);
    fp = fp + 32'h4;
  endtask
  task automatic s_load(input logic [8:0] f, input logic [31:0] a);
    logic [31:0] d;
    d = a ^ 32'h5A5A_0000;
    go(2'h3, f, a, 32'h0);
    bus(fp, 3'b000);
    step;
    bus(a, 3'b110);
    check("bw_n", {31'h0, byte_word_select_n_out}, {31'h0, !f[1]});
    step;
    bus(fp + 32'h4, {2'b10, !f[4]});
    wr(f[0], 4'h4, a);
    step;
    if (f[4]) begin
      bus(d, 3'b001);
      check("flush_blk", {30'h0, pipeline_flush_out, exception_block_out},
        32'h3);
      step;
      bus(d + 32'h4, 3'b001);
      fp = d + 32'h8;
    end else begin
      wr(!f[8], 4'h3, d);
      fp = fp + 32'h4;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_in = 1'b0;
    {start_in, abort_en, multiply_accumulate_op_in, link_in, shift_by_reg_in,
      dest_pc_in, compare_in, psr_transfer_in, byte_in} = 9'h0;
    base_writeback_in = 1'b0;
    set_flags_in = 1'b1;
    op_class_in = 2'h0;
    dest_idx_in = 4'h3;
    base_idx_in = 4'h4;
    alu_result_in = 32'h0;
    opa = 32'h0;
    accumulate_in = 32'h0000_0003;
    repeat (6) @(posedge clock_in);
    check("rst_ready", {31'h0, ready_out}, 32'h1);
    arst_n_in <= 1'b1;
    fp = seq_pkg::RESET_FETCH_ADDR;
    s_data(9'h000, 1'b1);
    s_data(9'h008, 1'b0);
    s_data(9'h014, 1'b1);
    s_refill(2'h0, 9'h040, 32'h0000_0100);
    s_refill(2'h1, 9'h010, 32'h0000_0200);
    s_shift;
    s_mul(9'h080, 32'h0000_0005, 32'h0000_001C);
    s_mul(9'h000, 32'h0000_0001, 32'h0000_0001);
    s_mul(9'h080, 32'h0000_0000, 32'h0000_0003);
    s_mul(9'h000, 32'h0000_0002, 32'h0000_0004);
    s_load(9'h003, 32'h0000_0300);
    s_load(9'h100, 32'h0000_0340);
    s_load(9'h010, 32'h0000_0400);
    s_refill(2'h0, 9'h000, 32'h0000_0500);
    print_verdict;
  end
  initial begin
    #20000;
    failures++;
    print_verdict;
  end
endmodule
